// ===== hw/ocmd_pkg.sv
// constants, types and carriers of the on-chip memory decoder
package ocmd_pkg;

  // ==========================================================
  // sizes
  localparam int ADDR_W      = 24;
  localparam int DATA_W      = 16;
  localparam int NPORT       = 4;
  localparam int PORT_W      = 2;
  localparam int BANK_WORDS  = 4096;
  localparam int DUAL_ACCESS_RAM_BANKS = 8;
  localparam int SINGLE_ACCESS_RAM_BANKS = 32;
  localparam int ROM_WORDS   = 16384;
  localparam int DUAL_ACCESS_RAM_WORDS = DUAL_ACCESS_RAM_BANKS * BANK_WORDS;
  localparam int SINGLE_ACCESS_RAM_WORDS = SINGLE_ACCESS_RAM_BANKS * BANK_WORDS;
  localparam int TOTAL_BYTES = 2 * (DUAL_ACCESS_RAM_WORDS + SINGLE_ACCESS_RAM_WORDS + ROM_WORDS);
  localparam int DUAL_ACCESS_RAM_AW    = 15;
  localparam int SINGLE_ACCESS_RAM_AW    = 17;
  localparam int BANK_ID_W   = 6;

  // ==========================================================
  // field positions
  localparam int WORD_LSB    = 1;
  localparam int BANK_LSB    = 13;
  localparam int DBANK_W     = 3;
  localparam int SBANK_W     = 5;
  localparam int SINE_IDX_W  = 8;

  // ==========================================================
  // byte map
  localparam logic [ADDR_W-1:0] MMR_BYTES  = 24'h0000c0;
  localparam logic [ADDR_W-1:0] DUAL_ACCESS_RAM_TOP  = 24'h00ffff;
  localparam logic [ADDR_W-1:0] SINGLE_ACCESS_RAM_BASE = 24'h010000;
  localparam logic [ADDR_W-1:0] SINGLE_ACCESS_RAM_TOP  = 24'h04ffff;
  localparam logic [ADDR_W-1:0] ROM_BASE   = 24'hff8000;
  localparam logic [ADDR_W-1:0] BOOT_TOP   = 24'hff8fff;
  localparam logic [ADDR_W-1:0] SINE_BASE  = 24'hfffa00;
  localparam logic [ADDR_W-1:0] SINE_TOP   = 24'hfffbff;
  localparam logic [ADDR_W-1:0] TEST_BASE  = 24'hfffc00;
  localparam logic [ADDR_W-1:0] TEST_TOP   = 24'hfffeff;
  localparam logic [ADDR_W-1:0] VEC_BASE   = 24'hffff00;
  localparam logic [ADDR_W-1:0] VEC_TOP    = 24'hfffffb;
  localparam logic [ADDR_W-1:0] ID_BASE    = 24'hfffffc;

  // ==========================================================
  // arbitration and strap
  localparam logic [1:0] DUAL_ACCESS_RAM_CAP    = 2'h2;
  localparam logic [1:0] SINGLE_ACCESS_RAM_CAP    = 2'h1;
  localparam logic [2:0] BOOT_ROM_OFF = 3'h0;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    RG_EXT   = 3'h0,
    RG_DUAL_ACCESS_RAM = 3'h1,
    RG_SINGLE_ACCESS_RAM = 3'h3,
    RG_ROM   = 3'h2,
    RG_MMR   = 3'h6
  } ocmd_region_e;

  typedef enum logic [1:0] {
    ROM_IDLE  = 2'h0,
    ROM_WAIT  = 2'h1,
    ROM_LAST  = 2'h3,
    ROM_CHAIN = 2'h2
  } ocmd_rom_state_e;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ocmd_req_s;

  typedef struct packed {
    logic              ready;
    logic              route_ext;
    logic              route_mmr;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
  } ocmd_rsp_s;

endpackage : ocmd_pkg

// ===== hw/ocmd_ram.sv
// flip-flop word storage with one write and one read lane per requester
`timescale 1ns/1ps
module ocmd_ram #(
  parameter int AW    = 15,
  parameter int WORDS = 32768
) (
  input  wire logic                                         clock,
  input  wire logic [ocmd_pkg::NPORT-1:0]                   we,
  input  wire logic [ocmd_pkg::NPORT-1:0][AW-1:0]           addr,
  input  wire logic [ocmd_pkg::NPORT-1:0][ocmd_pkg::DATA_W-1:0] wdata,
  output logic      [ocmd_pkg::NPORT-1:0][ocmd_pkg::DATA_W-1:0] rdata
);

  logic [ocmd_pkg::DATA_W-1:0] mem [WORDS];

  // ==========================================================
  // write lanes: the higher lane is applied last and wins a same-word clash
  always_ff @(posedge clock) begin
    for (int p = 0; p < ocmd_pkg::NPORT; p++) begin
      if (we[p]) begin
        mem[addr[p]] <= wdata[p];
      end
    end
  end

  // ==========================================================
  // read lanes, registered by the caller
  always_comb begin
    for (int p = 0; p < ocmd_pkg::NPORT; p++) begin
      rdata[p] = mem[addr[p]];
    end
  end

endmodule : ocmd_ram

// ===== hw/ocmd_rom.sv
// mask rom contents and its access timing
`timescale 1ns/1ps
module ocmd_rom #(
  parameter logic [31:0] ID_CODE = 32'h00005a3c  // arbitrary identification value
) (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          go,
  input  wire logic [ocmd_pkg::ADDR_W-1:0]   addr,
  output logic                               done,
  output logic      [ocmd_pkg::DATA_W-1:0]   word
);

  ocmd_pkg::ocmd_rom_state_e state;

  // ==========================================================
  // sine table, one full period, integer approximation in q15
  function automatic logic [15:0] sine_q15(input logic [7:0] i);
    int t;
    int p;
    int v;
    t = int'(i[6:0]);
    p = t * (128 - t);
    v = (32767 * 4 * p) / (20480 - p);
    if (i[7]) begin
      v = -v;
    end
    return 16'(v);
  endfunction : sine_q15

  // boot, test and vector areas are factory contents and read as zero here
  function automatic logic [15:0] rom_word(input logic [23:0] a);
    if (a >= ocmd_pkg::SINE_BASE && a <= ocmd_pkg::SINE_TOP) begin
      return sine_q15(a[ocmd_pkg::WORD_LSB +: ocmd_pkg::SINE_IDX_W]);
    end else if (a >= ocmd_pkg::ID_BASE) begin
      return a[ocmd_pkg::WORD_LSB] ? ID_CODE[31:16] : ID_CODE[15:0];
    end else begin
      return 16'h0000;
    end
  endfunction : rom_word

  assign word = rom_word(addr);

  // ==========================================================
  // first word three cycles, a back-to-back word two
  assign done = go && (state == ocmd_pkg::ROM_LAST);

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ocmd_pkg::ROM_IDLE;
    end else begin
      case (state)
        ocmd_pkg::ROM_IDLE:  state <= go ? ocmd_pkg::ROM_WAIT : ocmd_pkg::ROM_IDLE;
        ocmd_pkg::ROM_WAIT:  state <= go ? ocmd_pkg::ROM_LAST : ocmd_pkg::ROM_IDLE;
        ocmd_pkg::ROM_LAST:  state <= go ? ocmd_pkg::ROM_CHAIN : ocmd_pkg::ROM_IDLE;
        ocmd_pkg::ROM_CHAIN: state <= go ? ocmd_pkg::ROM_LAST : ocmd_pkg::ROM_IDLE;
        default:             state <= ocmd_pkg::ROM_IDLE;
      endcase
    end
  end

  property p_rom_first;
    @(posedge clock) disable iff (rst)
    (state == ocmd_pkg::ROM_IDLE && go) |-> !done ##1 (go && !done) ##1 (go && done);
  endproperty
  a_rom_first: assert property (p_rom_first) else $error("first rom word not in 3 cycles");

  property p_rom_next;
    @(posedge clock) disable iff (rst)
    (done ##1 go) |-> !done ##1 (!go || done);
  endproperty
  a_rom_next: assert property (p_rom_next) else $error("next rom word not in 2 cycles");

endmodule : ocmd_rom

// ===== hw/ocmd_decoder.sv
// on-chip memory decoder: map, bank arbitration, rom timing and rom-off flag
`timescale 1ns/1ps

// How it works
// - one 352K-byte space of 16-bit words serves program and data alike
// - bytes 000000h-00ffffh are eight dual-access banks of 8K bytes
// - a dual-access bank serves two accesses of any kind per cycle
// - dual-access banks are open to program, data and dma requesters
// - the lowest 192 bytes of bank 0 go to the mapped register space
// - bytes 010000h-04ffffh are 32 single-access banks of 8K bytes
// - a single-access bank serves one read or one write per cycle
// - single-access banks are open to program, data and dma requesters
// - with the flag clear, a 32K-byte rom sits from ff8000h to the top
// - with the flag set, that range goes to external memory instead
// - at hardware reset the flag is set when boot pins low are all zero
// - the pins are sampled only at hardware reset; soft reset keeps the flag
// - software may write the flag through status word three
// - the rom is readable by program, data and dma requesters
// - a first rom word takes three cycles, each following word two
// - rom holds 256 q15 sine entries at fffa00h-fffbffh
// - rom layout: bootloader, reserved, test code, vectors, id code
module ocmd_decoder (
  input  wire logic                                  clock,
  input  wire logic                                  rst,
  input  wire logic [2:0]                            boot_select_pins_low,
  input  wire logic                                  st3_wr,
  input  wire logic                                  st3_flag_wdata,
  input  wire ocmd_pkg::ocmd_req_s [ocmd_pkg::NPORT-1:0] req,
  output ocmd_pkg::ocmd_rsp_s      [ocmd_pkg::NPORT-1:0] rsp,
  output logic                                       rom_disable_flag
);

  localparam int NP = ocmd_pkg::NPORT;
  localparam int DW = ocmd_pkg::DATA_W;

  // ==========================================================
  // address decoding
  function automatic ocmd_pkg::ocmd_region_e region_of(input logic [23:0] a,
                                                       input logic rom_off);
    if (a < ocmd_pkg::MMR_BYTES) begin
      return ocmd_pkg::RG_MMR;
    end else if (a <= ocmd_pkg::DUAL_ACCESS_RAM_TOP) begin
      return ocmd_pkg::RG_DUAL_ACCESS_RAM;
    end else if (a >= ocmd_pkg::SINGLE_ACCESS_RAM_BASE && a <= ocmd_pkg::SINGLE_ACCESS_RAM_TOP) begin
      return ocmd_pkg::RG_SINGLE_ACCESS_RAM;
    end else if (a >= ocmd_pkg::ROM_BASE && !rom_off) begin
      return ocmd_pkg::RG_ROM;
    end else begin
      return ocmd_pkg::RG_EXT;
    end
  endfunction : region_of

  function automatic logic [23:0] single_access_ram_offset(input logic [23:0] a);
    return a - ocmd_pkg::SINGLE_ACCESS_RAM_BASE;
  endfunction : single_access_ram_offset

  // dual-access banks are ids 0..7, single-access banks follow
  function automatic logic [5:0] bank_of(input logic [23:0] a);
    logic [23:0] off;
    off = single_access_ram_offset(a);
    if (a <= ocmd_pkg::DUAL_ACCESS_RAM_TOP) begin
      return {3'h0, a[ocmd_pkg::BANK_LSB +: ocmd_pkg::DBANK_W]};
    end else begin
      return 6'(ocmd_pkg::DUAL_ACCESS_RAM_BANKS) + {1'b0, off[ocmd_pkg::BANK_LSB +: ocmd_pkg::SBANK_W]};
    end
  endfunction : bank_of

  function automatic logic [ocmd_pkg::DUAL_ACCESS_RAM_AW-1:0] dual_access_ram_index(input logic [23:0] a);
    return a[ocmd_pkg::WORD_LSB +: ocmd_pkg::DUAL_ACCESS_RAM_AW];
  endfunction : dual_access_ram_index

  function automatic logic [ocmd_pkg::SINGLE_ACCESS_RAM_AW-1:0] single_access_ram_index(input logic [23:0] a);
    logic [23:0] off;
    off = single_access_ram_offset(a);
    return off[ocmd_pkg::WORD_LSB +: ocmd_pkg::SINGLE_ACCESS_RAM_AW];
  endfunction : single_access_ram_index

  // ==========================================================
  // rom-off flag
  logic [2:0] boot_meta;
  logic [2:0] boot_sync;

  // not reset, so the strap reaches the flag while reset is held
  always_ff @(posedge clock) begin
    boot_meta <= boot_select_pins_low;
    boot_sync <= boot_meta;
  end

  // only hardware reset samples the pins; no other reset touches the flag
  always_ff @(posedge clock) begin
    if (rst) begin
      rom_disable_flag <= (boot_sync == ocmd_pkg::BOOT_ROM_OFF);
    end else if (st3_wr) begin
      rom_disable_flag <= st3_flag_wdata;
    end
  end

  // ==========================================================
  // per-requester decode and ram bank arbitration
  ocmd_pkg::ocmd_region_e region [NP];
  logic [5:0]             bank   [NP];
  logic [1:0]             hits   [NP];
  logic [NP-1:0]          ram_grant;
  logic [NP-1:0]          rom_req;

  // fixed priority, lowest index first; a low lane can starve a higher one
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      region[p] = region_of(req[p].addr, rom_disable_flag);
      bank[p]   = bank_of(req[p].addr);
      rom_req[p] = req[p].valid && (region[p] == ocmd_pkg::RG_ROM);
    end
    for (int p = 0; p < NP; p++) begin
      hits[p] = 2'h0;
      for (int q = 0; q < p; q++) begin
        if (req[q].valid && region[q] == region[p] && bank[q] == bank[p]) begin
          hits[p] = hits[p] + 2'h1;
        end
      end
      ram_grant[p] = req[p].valid &&
        ((region[p] == ocmd_pkg::RG_DUAL_ACCESS_RAM && hits[p] < ocmd_pkg::DUAL_ACCESS_RAM_CAP) ||
         (region[p] == ocmd_pkg::RG_SINGLE_ACCESS_RAM && hits[p] < ocmd_pkg::SINGLE_ACCESS_RAM_CAP));
    end
  end

  // ==========================================================
  // ram storage
  logic [NP-1:0]                         dar_we;
  logic [NP-1:0]                         sar_we;
  logic [NP-1:0][ocmd_pkg::DUAL_ACCESS_RAM_AW-1:0] dar_addr;
  logic [NP-1:0][ocmd_pkg::SINGLE_ACCESS_RAM_AW-1:0] sar_addr;
  logic [NP-1:0][DW-1:0]                 wdata;
  logic [NP-1:0][DW-1:0]                 dar_rd;
  logic [NP-1:0][DW-1:0]                 sar_rd;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      dar_we[p]   = ram_grant[p] && req[p].write && region[p] == ocmd_pkg::RG_DUAL_ACCESS_RAM;
      sar_we[p]   = ram_grant[p] && req[p].write && region[p] == ocmd_pkg::RG_SINGLE_ACCESS_RAM;
      dar_addr[p] = dual_access_ram_index(req[p].addr);
      sar_addr[p] = single_access_ram_index(req[p].addr);
      wdata[p]    = req[p].wdata;
    end
  end

  // sizes add to TOTAL_BYTES with the rom
  ocmd_ram #(
    .AW    (ocmd_pkg::DUAL_ACCESS_RAM_AW),
    .WORDS (ocmd_pkg::DUAL_ACCESS_RAM_WORDS)
  ) u_dual_access_ram (
    .clock (clock),
    .we    (dar_we),
    .addr  (dar_addr),
    .wdata (wdata),
    .rdata (dar_rd)
  );

  ocmd_ram #(
    .AW    (ocmd_pkg::SINGLE_ACCESS_RAM_AW),
    .WORDS (ocmd_pkg::SINGLE_ACCESS_RAM_WORDS)
  ) u_single_access_ram (
    .clock (clock),
    .we    (sar_we),
    .addr  (sar_addr),
    .wdata (wdata),
    .rdata (sar_rd)
  );

  // ==========================================================
  // rom ownership: the owner is held until its word is done
  logic [ocmd_pkg::PORT_W-1:0] rom_owner;
  logic [ocmd_pkg::PORT_W-1:0] rom_pick;
  logic                        rom_locked;
  logic                        rom_go;
  logic                        rom_done;
  logic [DW-1:0]               rom_word;

  always_comb begin
    rom_pick = rom_owner;
    if (!rom_locked) begin
      rom_pick = '0;
      for (int p = NP - 1; p >= 0; p--) begin
        if (rom_req[p]) begin
          rom_pick = ocmd_pkg::PORT_W'(p);
        end
      end
    end
    rom_go = rom_req[rom_pick];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rom_locked <= 1'b0;
      rom_owner  <= '0;
    end else begin
      rom_locked <= rom_go && !rom_done;
      rom_owner  <= rom_pick;
    end
  end

  ocmd_rom u_rom (
    .clock (clock),
    .rst   (rst),
    .go    (rom_go),
    .addr  (req[rom_pick].addr),
    .done  (rom_done),
    .word  (rom_word)
  );

  // ==========================================================
  // answers
  logic [NP-1:0]         ready;
  logic [NP-1:0]         rvalid_q;
  logic [NP-1:0][DW-1:0] rdata_q;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      ready[p]            = ram_grant[p] || (rom_done && rom_pick == ocmd_pkg::PORT_W'(p));
      rsp[p].ready        = ready[p];
      rsp[p].route_ext    = req[p].valid && region[p] == ocmd_pkg::RG_EXT;
      rsp[p].route_mmr    = req[p].valid && region[p] == ocmd_pkg::RG_MMR;
      rsp[p].rvalid       = rvalid_q[p];
      rsp[p].rdata        = rdata_q[p];
    end
  end

  // rom writes complete with rom timing but store nothing
  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_q <= '0;
      rdata_q  <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        rvalid_q[p] <= ready[p] && !req[p].write;
        if (ready[p] && !req[p].write) begin
          case (region[p])
            ocmd_pkg::RG_DUAL_ACCESS_RAM: rdata_q[p] <= dar_rd[p];
            ocmd_pkg::RG_SINGLE_ACCESS_RAM: rdata_q[p] <= sar_rd[p];
            default:            rdata_q[p] <= rom_word;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // checks
  property p_strap;
    @(posedge clock)
    rst [*3] |=> (rom_disable_flag == ($past(boot_sync) == ocmd_pkg::BOOT_ROM_OFF));
  endproperty
  a_strap: assert property (p_strap) else $error("flag not taken from boot pins");

  property p_hold;
    @(posedge clock) disable iff (rst)
    !st3_wr |=> $stable(rom_disable_flag);
  endproperty
  a_hold: assert property (p_hold) else $error("flag changed without a write");

  property p_swwr;
    @(posedge clock) disable iff (rst)
    st3_wr |=> rom_disable_flag == $past(st3_flag_wdata);
  endproperty
  a_swwr: assert property (p_swwr) else $error("software flag write lost");

  property p_romoff;
    @(posedge clock) disable iff (rst)
    (req[3].valid && req[3].addr >= ocmd_pkg::ROM_BASE && rom_disable_flag)
      |-> rsp[3].route_ext && !rsp[3].ready;
  endproperty
  a_romoff: assert property (p_romoff) else $error("rom range not sent outside");

  property p_romon;
    @(posedge clock) disable iff (rst)
    (req[3].valid && req[3].addr >= ocmd_pkg::ROM_BASE && !rom_disable_flag)
      |-> !rsp[3].route_ext && !rsp[3].route_mmr;
  endproperty
  a_romon: assert property (p_romon) else $error("rom range left the rom");

  property p_mmr;
    @(posedge clock) disable iff (rst)
    (req[3].valid && req[3].addr < ocmd_pkg::MMR_BYTES) |-> rsp[3].route_mmr && !rsp[3].ready;
  endproperty
  a_mmr: assert property (p_mmr) else $error("register space served as ram");

  property p_dar_pair;
    @(posedge clock) disable iff (rst)
    (req[0].valid && req[1].valid && region[0] == ocmd_pkg::RG_DUAL_ACCESS_RAM &&
     region[1] == ocmd_pkg::RG_DUAL_ACCESS_RAM && bank[0] == bank[1]) |-> rsp[0].ready && rsp[1].ready;
  endproperty
  a_dar_pair: assert property (p_dar_pair) else $error("dual bank refused a pair");

  property p_sar_clash;
    @(posedge clock) disable iff (rst)
    (req[2].valid && req[3].valid && region[2] == ocmd_pkg::RG_SINGLE_ACCESS_RAM &&
     region[3] == ocmd_pkg::RG_SINGLE_ACCESS_RAM && bank[2] == bank[3]) |-> !rsp[3].ready;
  endproperty
  a_sar_clash: assert property (p_sar_clash) else $error("single bank served two");

  property p_rdata;
    @(posedge clock) disable iff (rst)
    (rsp[2].ready && !req[2].write) |=> rsp[2].rvalid;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not returned");

endmodule : ocmd_decoder

// ===== verif/ocmd_requester.sv
// requester lanes standing in for the program, data and dma buses
`timescale 1ns/1ps
module ocmd_requester (
  input  wire logic                                      clock,
  input  wire logic [3:0]                                start,
  input  wire ocmd_pkg::ocmd_req_s [ocmd_pkg::NPORT-1:0] cmd,
  input  wire ocmd_pkg::ocmd_rsp_s [ocmd_pkg::NPORT-1:0] rsp,
  output ocmd_pkg::ocmd_req_s      [ocmd_pkg::NPORT-1:0] req,
  output logic      [3:0]                                taken
);
  initial begin
    req   = '0;
    taken = 4'h0;
  end

  // ==========================================================
  // completion
  // non-blocking, so the edge sees ready from before the design's own update
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      taken[i] <= req[i].valid && rsp[i].ready;
    end
  end

  // ==========================================================
  // request lanes
  // a request changes only at the falling edge and stands until taken
  always @(negedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (start[i]) begin
        req[i] = cmd[i];
      end else if (taken[i]) begin
        // a released lane shows inverted garbage rather than its last request
        req[i].valid = 1'b0;
        req[i].addr  = ~req[i].addr;
        req[i].wdata = ~req[i].wdata;
      end
    end
  end
endmodule : ocmd_requester

// ===== verif/ocmd_decoder_tb.sv
// self-checking bench for the on-chip memory decoder
`timescale 1ns/1ps
module ocmd_decoder_tb;
  localparam logic [31:0] ID_CODE = 32'h00005a3c;  // arbitrary value, the rom's default
  logic                                      clock;
  logic                                      rst;
  logic [2:0]                                pins;
  logic                                      st3_wr;
  logic                                      st3_wdata;
  logic [3:0]                                start;
  logic [3:0]                                taken;
  logic                                      flag;
  ocmd_pkg::ocmd_req_s [ocmd_pkg::NPORT-1:0] cmd;
  ocmd_pkg::ocmd_req_s [ocmd_pkg::NPORT-1:0] req;
  ocmd_pkg::ocmd_rsp_s [ocmd_pkg::NPORT-1:0] rsp;
  logic [15:0]                               mem [int];
  logic [16:0]                               expq [4][$];
  int                                        lat [4];
  int                                        errors = 0;
  int                                        comparisons = 0;

  ocmd_decoder ocmd_decoder_i (.clock(clock), .rst(rst), .boot_select_pins_low(pins),
    .st3_wr(st3_wr), .st3_flag_wdata(st3_wdata), .req(req), .rsp(rsp),
    .rom_disable_flag(flag));
  ocmd_requester ocmd_requester_i (.clock(clock), .start(start), .cmd(cmd), .rsp(rsp),
    .req(req), .taken(taken));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // checking and closing
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  initial begin
    #100000;
    errors++;
    close_out();
  end

  // read data stands for the cycle after the completing edge; looked at mid-cycle,
  // after run has booked the expectation
  always @(negedge clock) begin
    logic [16:0] e;
    for (int i = 0; i < 4; i++) begin
      if (rsp[i].rvalid === 1'b1) begin
        if (expq[i].size() == 0) begin
          check("rvalid", 32'h1, 32'h0);
        end else begin
          e = expq[i].pop_front();
          if (e[16]) check("rdata", rsp[i].rdata, e[15:0]);
        end
      end
    end
  end

  // ==========================================================
  // reference model
  // only the words with a known value are compared; the rest of the rom is unchecked
  function automatic logic [16:0] rom_exp(input logic [23:0] a);
    case ({a[23:1], 1'b0})
      ocmd_pkg::ID_BASE:            return {1'b1, ID_CODE[15:0]};
      ocmd_pkg::ID_BASE + 24'h2:    return {1'b1, ID_CODE[31:16]};
      ocmd_pkg::SINE_BASE:          return 17'h10000;
      ocmd_pkg::SINE_BASE + 24'h80: return 17'h17fff;
      ocmd_pkg::ROM_BASE:           return 17'h10000;
      default:                      return 17'h00000;
    endcase
  endfunction : rom_exp

  task automatic book(input int i);
    int w;
    w = int'(cmd[i].addr[23:1]);
    if (cmd[i].addr >= ocmd_pkg::ROM_BASE) begin
      if (!cmd[i].write) expq[i].push_back(rom_exp(cmd[i].addr));
    end else if (cmd[i].write) begin
      mem[w] = cmd[i].wdata;
    end else begin
      expq[i].push_back(mem.exists(w) ? {1'b1, mem[w]} : 17'h0);
    end
  endtask : book

  // ==========================================================
  // stimulus
  task automatic do_reset(input logic [2:0] p);
    @(negedge clock);
    rst  = 1'b1;
    pins = p;
    repeat (16) @(negedge clock);
    rst = 1'b0;
  endtask : do_reset

  task automatic st3(input logic v);
    @(negedge clock);
    st3_wr    = 1'b1;
    st3_wdata = v;
    @(negedge clock);
    st3_wr = 1'b0;
  endtask : st3

  task automatic lane(input int i, input logic w, input logic [23:0] a, input logic [15:0] d);
    cmd[i] = {1'b1, w, a, d};
  endtask : lane

  task automatic pulse(input logic [3:0] m);
    @(posedge clock);
    #1 start = m;
    @(negedge clock);
    #1 start = 4'h0;
  endtask : pulse

  // lat holds how many rising edges each lane needed, counting its first one as 1
  task automatic run(input logic [3:0] m);
    int n;
    logic [3:0] pend;
    pend = m;
    n    = 0;
    pulse(m);
    while (pend != 4'h0 && n < 40) begin
      @(posedge clock);
      #1 n++;
      for (int i = 0; i < 4; i++) begin
        if (pend[i] && taken[i]) begin
          lat[i]  = n;
          pend[i] = 1'b0;
          book(i);
        end
      end
    end
    check("stalled lanes", pend, 4'h0);
  endtask : run

  task automatic chk_lat(input int l0, input int l1, input int l2, input int l3);
    check("lat0", lat[0], l0);
    check("lat1", lat[1], l1);
    check("lat2", lat[2], l2);
    check("lat3", lat[3], l3);
  endtask : chk_lat

  // expected bits are {route_ext, route_mmr, ready}; the request is then withdrawn
  task automatic probe(input logic [23:0] a, input logic [2:0] exp);
    lane(3, 1'b0, a, 16'h0);
    pulse(4'h8);
    repeat (3) @(posedge clock);
    #1 check("route", {rsp[3].route_ext, rsp[3].route_mmr, rsp[3].ready}, exp);
    cmd[3] = {1'b0, 1'b0, 24'($urandom), 16'($urandom)};
    pulse(4'h8);
  endtask : probe

  task automatic reads();
    for (int i = 0; i < 4; i++) cmd[i].write = 1'b0;
    run(4'hf);
  endtask : reads

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    pins = 3'h0;
    st3_wr = 1'b0;
    st3_wdata = 1'b0;
    start = 4'h0;
    cmd = '0;
    void'($urandom(32'h22be));
    for (int p = 7; p >= 0; p--) begin
      do_reset(3'(p));
      @(negedge clock);
      check("flag", flag, p == 0);
    end
    pins = 3'h5;
    repeat (4) @(negedge clock);
    check("flag", flag, 1'b1);
    probe(24'hff8000, 3'h4);
    probe(24'hfffffe, 3'h4);
    st3(1'b0);
    check("flag", flag, 1'b0);
    probe(24'h000000, 3'h2);
    probe(24'h0000be, 3'h2);
    probe(24'h050000, 3'h4);
    probe(24'hff7ffe, 3'h4);
    // rom: a waiting lane chains straight after the owner
    lane(0, 1'b0, ocmd_pkg::ROM_BASE, 16'h0);
    lane(1, 1'b0, ocmd_pkg::SINE_BASE + 24'h80, 16'h0);
    run(4'h3);
    chk_lat(3, 5, lat[2], lat[3]);
    lane(2, 1'b0, ocmd_pkg::ID_BASE, 16'h0);
    run(4'h4);
    chk_lat(lat[0], lat[1], 3, lat[3]);
    lane(0, 1'b0, ocmd_pkg::ID_BASE + 24'h2, 16'h0);
    lane(1, 1'b1, ocmd_pkg::ROM_BASE, 16'hffff);
    lane(3, 1'b0, ocmd_pkg::SINE_BASE, 16'h0);
    run(4'hb);
    chk_lat(3, 5, lat[2], 7);
    lane(2, 1'b0, ocmd_pkg::ROM_BASE, 16'h0);
    run(4'h4);
    st3(1'b1);
    check("flag", flag, 1'b1);
    st3(1'b0);
    // dual bank: two per cycle; lanes 2 and 3 write one word, the higher lane wins
    for (int i = 0; i < 4; i++) lane(i, 1'b1, 24'h006000 + 24'(8 * (i - i / 3)), 16'($urandom));
    run(4'hf);
    chk_lat(1, 1, 2, 2);
    reads();
    chk_lat(1, 1, 2, 2);
    // single bank: one per cycle, index 0 first
    for (int i = 0; i < 4; i++) lane(i, 1'b1, 24'h030000 + 24'(8 * i), 16'($urandom));
    run(4'hf);
    chk_lat(1, 2, 3, 4);
    reads();
    chk_lat(1, 2, 3, 4);
    // edges of the map, one bank each
    lane(0, 1'b1, 24'h0000c0, 16'($urandom));
    lane(1, 1'b1, 24'h00fffe, 16'($urandom));
    lane(2, 1'b1, 24'h010000, 16'($urandom));
    lane(3, 1'b1, 24'h04fffe, 16'($urandom));
    run(4'hf);
    chk_lat(1, 1, 1, 1);
    reads();
    chk_lat(1, 1, 1, 1);
    // random traffic; lanes never share a word, so same-cycle order does not matter
    for (int k = 0; k < 16; k++) begin
      for (int i = 0; i < 4; i++) begin
        lane(i, 1'b1, ($urandom % 2 == 0 ? 24'h002000 * 24'($urandom % 7 + 1)
                      : 24'h010000 + 24'h002000 * 24'($urandom % 32))
                      + 24'(8 * i + 32 * ($urandom % 64)), 16'($urandom));
      end
      run(4'hf);
      reads();
    end
    repeat (3) @(posedge clock);
    close_out();
  end
endmodule : ocmd_decoder_tb
